// ### common/cod_defs.svh
// Summary of operation
// - Security on blocks program read-back
// - Emission option dithers the system clock
// - Sixteen-level low-voltage reset threshold decode
// - Enabled PWM generators use 16 or 32 MHz
// - Comparator optionally gates PWM outputs
// - Comparator interrupt on both, rising, falling
// - Interrupt bit 0 from A0 or B5
// - Interrupt bit 1 from B0 or A4
`ifndef COD_DEFS_SVH
`define COD_DEFS_SVH

`define COD_OPT_W 16
`define COD_OPT_SEC_BIT 0
`define COD_OPT_EMI_BIT 1
`define COD_OPT_LVR_LSB 2
`define COD_OPT_LVR_MSB 5
`define COD_OPT_PWM32_BIT 6
`define COD_OPT_GATE_BIT 7
`define COD_OPT_EDGE_LSB 8
`define COD_OPT_EDGE_MSB 9
`define COD_OPT_SRC0_BIT 10
`define COD_OPT_SRC1_BIT 11

`define COD_ADDR_W 4
`define COD_DATA_W 16
`define COD_REG_STATUS 4'h0
`define COD_REG_MASK 4'h1
`define COD_REG_OPTION 4'h2
`define COD_MASK_RST 3'h0
`define COD_STATUS_RST 3'h0

`define COD_EVT_CMP 0
`define COD_EVT_SRC0 1
`define COD_EVT_SRC1 2
`define COD_EVT_W 3

`define COD_DITHER_PERIOD 16

`endif

// ### common/cod_pkg.sv
`default_nettype none
package cod_pkg;

    typedef enum logic [1:0] {
        COD_EDGE_ALL,
        COD_EDGE_RISE,
        COD_EDGE_FALL,
        COD_EDGE_SPARE
    } cod_edge_t;

    typedef enum logic [1:0] {
        COD_ST_LOAD,
        COD_ST_RUN
    } cod_state_t;

    typedef struct packed {
        logic src1_alt;
        logic src0_alt;
        cod_edge_t edge_sel;
        logic gate;
        logic pwm_fast;
        logic [3:0] low_voltage_reset;
        logic emi;
        logic security;
    } cod_opt_t;

endpackage
`default_nettype wire

// ### common/cod_dith_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cod_dith_if;
    logic enable;
    logic [1:0] step;
    modport ctl (output enable, input step);
    modport gen (input enable, output step);
endinterface
`default_nettype wire

// ### rtl/cod_dither.sv
`timescale 1ns/1ns
`default_nettype none
`include "cod_defs.svh"
module cod_dither
    import cod_pkg::*;
#(
    parameter int PERIOD = `COD_DITHER_PERIOD
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    cod_dith_if.gen dith
);
    generate
        if (PERIOD < 2 || PERIOD > 256) begin : g_bad
            $error("cod_dither PERIOD out of range");
        end
    endgenerate

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic dir_reg;
    logic dir_next;
    logic [1:0] step_reg;
    logic [1:0] step_next;

    // Triangle sweep: up steps then down steps, trims the oscillator slightly
    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        step_next = 2'h0;
        if (dith.enable) begin
            step_next = dir_reg ? 2'h3 : 2'h1;
            if (cnt_reg == 8'(PERIOD - 1)) begin
                cnt_next = 8'h00;
                dir_next = ~dir_reg;
            end else begin
                cnt_next = cnt_reg + 8'h01;
            end
        end else begin
            cnt_next = 8'h00;
            dir_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            dir_reg <= 1'b0;
            step_reg <= 2'h0;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            step_reg <= step_next;
        end
    end

    assign dith.step = step_reg;

    a_dither_moves: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(dith.enable) |-> dith.step != 2'h0)
        else $error("dither idle while enabled");
    a_dither_still: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && !$past(dith.enable) |-> dith.step == 2'h0)
        else $error("dither active while disabled");
    c_dither_turn: cover property (@(posedge mclk) disable iff (!rst_n)
        dith.step == 2'h1 ##1 dith.step == 2'h3);
endmodule
`default_nettype wire

// ### rtl/cod_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cod_defs.svh"
module cod_top
    import cod_pkg::*;
#(
    parameter int DITHER_PERIOD = `COD_DITHER_PERIOD
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`COD_OPT_W-1:0] option_word,
    output logic options_valid,
    input wire logic prog_rd_req,
    input wire logic [15:0] prog_rd_data_in,
    output logic [15:0] prog_rd_data,
    output logic prog_rd_valid,
    output logic prog_rd_refused,
    output logic [1:0] sysclk_dither,
    output logic [3:0] lvr_sel,
    output logic [12:0] lvr_threshold_mv,
    input wire logic [2:0] pwm_ctrl_bit0,
    output logic [2:0] pwm_src_oscillator,
    output logic [2:0] pwm_src_doubled,
    input wire logic [2:0] pwm_raw,
    input wire logic comparator_out,
    output logic [2:0] pwm_out,
    output logic comparator_irq_event,
    input wire logic port_a_bit0,
    input wire logic port_b_bit5,
    input wire logic port_b_bit0,
    input wire logic port_a_bit4,
    output logic int_src0,
    output logic int_src1,
    input wire logic [`COD_ADDR_W-1:0] reg_addr,
    input wire logic [`COD_DATA_W-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [`COD_DATA_W-1:0] reg_rdata,
    output logic irq
);
    generate
        if (`COD_OPT_W < 12 || `COD_DATA_W < `COD_OPT_W) begin : g_bad
            $error("cod_top option or data width too small");
        end
    endgenerate

    function automatic logic [12:0] cod_lvr_mv(input logic [3:0] sel);
        case (sel)
            4'h0: cod_lvr_mv = 13'h1194;
            4'h1: cod_lvr_mv = 13'h0FA0;
            4'h2: cod_lvr_mv = 13'h0EA6;
            4'h3: cod_lvr_mv = 13'h0DAC;
            4'h4: cod_lvr_mv = 13'h0CE4;
            4'h5: cod_lvr_mv = 13'h0C4E;
            4'h6: cod_lvr_mv = 13'h0BB8;
            4'h7: cod_lvr_mv = 13'h0A8C;
            4'h8: cod_lvr_mv = 13'h09C4;
            4'h9: cod_lvr_mv = 13'h0960;
            4'hA: cod_lvr_mv = 13'h08FC;
            4'hB: cod_lvr_mv = 13'h0898;
            4'hC: cod_lvr_mv = 13'h0834;
            4'hD: cod_lvr_mv = 13'h07D0;
            4'hE: cod_lvr_mv = 13'h076C;
            default: cod_lvr_mv = 13'h0708;
        endcase
    endfunction

    // Spare edge code behaves as both edges
    function automatic logic cod_edge_hit(input cod_edge_t sel, input logic prev,
                                          input logic cur);
        case (sel)
            COD_EDGE_RISE: cod_edge_hit = !prev && cur;
            COD_EDGE_FALL: cod_edge_hit = prev && !cur;
            default: cod_edge_hit = prev != cur;
        endcase
    endfunction

    cod_state_t state_reg;
    cod_state_t state_next;
    cod_opt_t opt_reg;
    cod_opt_t opt_next;

    // Options are caught once, in the first enabled cycle after reset release
    always_comb begin
        state_next = state_reg;
        opt_next = opt_reg;
        case (state_reg)
            COD_ST_LOAD: begin
                opt_next.security = option_word[`COD_OPT_SEC_BIT];
                opt_next.emi = option_word[`COD_OPT_EMI_BIT];
                opt_next.low_voltage_reset = option_word[`COD_OPT_LVR_MSB:`COD_OPT_LVR_LSB];
                opt_next.pwm_fast = option_word[`COD_OPT_PWM32_BIT];
                opt_next.gate = option_word[`COD_OPT_GATE_BIT];
                opt_next.edge_sel = cod_edge_t'(option_word[`COD_OPT_EDGE_MSB:`COD_OPT_EDGE_LSB]);
                opt_next.src0_alt = option_word[`COD_OPT_SRC0_BIT];
                opt_next.src1_alt = option_word[`COD_OPT_SRC1_BIT];
                state_next = COD_ST_RUN;
            end
            COD_ST_RUN: begin
                opt_next = opt_reg;
            end
            default: state_next = COD_ST_LOAD;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= COD_ST_LOAD;
            opt_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            opt_reg <= opt_next;
        end
    end

    logic run;
    assign run = state_reg == COD_ST_RUN;
    assign options_valid = run;

    cod_dith_if dith ();
    assign dith.enable = run && opt_reg.emi;
    assign sysclk_dither = dith.step;

    cod_dither #(
        .PERIOD(DITHER_PERIOD)
    ) u_dither (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .dith(dith)
    );

    logic [15:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic rd_refused_reg, rd_refused_next;
    logic [3:0] lvr_sel_reg, lvr_sel_next;
    logic [12:0] lvr_mv_reg, lvr_mv_next;
    logic [2:0] src_osc_reg, src_osc_next;
    logic [2:0] src_dbl_reg, src_dbl_next;
    logic [2:0] pwm_out_reg, pwm_out_next;
    logic cmp_q_reg, cmp_q_next;
    logic cmp_evt_reg, cmp_evt_next;
    logic src0_reg, src0_next;
    logic src1_reg, src1_next;

    always_comb begin
        rd_data_next = 16'h0000;
        rd_valid_next = 1'b0;
        rd_refused_next = 1'b0;
        if (prog_rd_req && run) begin
            if (opt_reg.security) begin
                rd_refused_next = 1'b1;
            end else begin
                rd_valid_next = 1'b1;
                rd_data_next = prog_rd_data_in;
            end
        end
        lvr_sel_next = opt_reg.low_voltage_reset;
        lvr_mv_next = cod_lvr_mv(opt_reg.low_voltage_reset);
        src_osc_next = pwm_ctrl_bit0 & {3{run}};
        src_dbl_next = src_osc_next & {3{opt_reg.pwm_fast}};
        // Gating ANDs the comparator level, no resync of the PWM edge
        pwm_out_next = opt_reg.gate ? (pwm_raw & {3{comparator_out}}) : pwm_raw;
        cmp_q_next = comparator_out;
        cmp_evt_next = run && cod_edge_hit(opt_reg.edge_sel, cmp_q_reg, comparator_out);
        src0_next = opt_reg.src0_alt ? port_b_bit5 : port_a_bit0;
        src1_next = opt_reg.src1_alt ? port_a_bit4 : port_b_bit0;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
            rd_refused_reg <= 1'b0;
            lvr_sel_reg <= 4'h0;
            lvr_mv_reg <= 13'h0000;
            src_osc_reg <= 3'h0;
            src_dbl_reg <= 3'h0;
            pwm_out_reg <= 3'h0;
            cmp_q_reg <= 1'b0;
            cmp_evt_reg <= 1'b0;
            src0_reg <= 1'b0;
            src1_reg <= 1'b0;
        end else if (clk_en) begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            rd_refused_reg <= rd_refused_next;
            lvr_sel_reg <= lvr_sel_next;
            lvr_mv_reg <= lvr_mv_next;
            src_osc_reg <= src_osc_next;
            src_dbl_reg <= src_dbl_next;
            pwm_out_reg <= pwm_out_next;
            cmp_q_reg <= cmp_q_next;
            cmp_evt_reg <= cmp_evt_next;
            src0_reg <= src0_next;
            src1_reg <= src1_next;
        end
    end

    assign prog_rd_data = rd_data_reg;
    assign prog_rd_valid = rd_valid_reg;
    assign prog_rd_refused = rd_refused_reg;
    assign lvr_sel = lvr_sel_reg;
    assign lvr_threshold_mv = lvr_mv_reg;
    assign pwm_src_oscillator = src_osc_reg;
    assign pwm_src_doubled = src_dbl_reg;
    assign pwm_out = pwm_out_reg;
    assign comparator_irq_event = cmp_evt_reg;
    assign int_src0 = src0_reg;
    assign int_src1 = src1_reg;

    logic [`COD_EVT_W-1:0] status_reg, status_next;
    logic [`COD_EVT_W-1:0] mask_reg, mask_next;
    logic [`COD_DATA_W-1:0] rdata_reg, rdata_next;
    logic [`COD_EVT_W-1:0] evt;
    logic src0_q_reg, src1_q_reg;
    logic [1:0] live_reg;

    // Source events are rising edges of the selected pins
    // Held off until the pin choice has settled, so a pin high at reset is no edge
    assign evt = {src1_reg && !src1_q_reg && live_reg[1],
        src0_reg && !src0_q_reg && live_reg[1],
        cmp_evt_reg};

    always_comb begin
        status_next = status_reg;
        mask_next = mask_reg;
        rdata_next = '0;
        if (reg_we && reg_addr == `COD_REG_STATUS) begin
            status_next = status_reg & ~reg_wdata[`COD_EVT_W-1:0];
        end
        if (reg_we && reg_addr == `COD_REG_MASK) begin
            mask_next = reg_wdata[`COD_EVT_W-1:0];
        end
        // Set after clear so a same-cycle event survives
        status_next = status_next | evt;
        if (reg_re) begin
            case (reg_addr)
                `COD_REG_STATUS: rdata_next = {{(`COD_DATA_W-`COD_EVT_W){1'b0}}, status_reg};
                `COD_REG_MASK: rdata_next = {{(`COD_DATA_W-`COD_EVT_W){1'b0}}, mask_reg};
                `COD_REG_OPTION: rdata_next = {{(`COD_DATA_W-12){1'b0}}, opt_reg};
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_reg <= `COD_STATUS_RST;
            mask_reg <= `COD_MASK_RST;
            rdata_reg <= '0;
            src0_q_reg <= 1'b0;
            src1_q_reg <= 1'b0;
            live_reg <= 2'h0;
        end else if (clk_en) begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            src0_q_reg <= src0_reg;
            src1_q_reg <= src1_reg;
            live_reg <= {live_reg[0], run};
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq = |(status_reg & mask_reg);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_sec_refuse: assert property ($past(clk_en)
        && $past(run && prog_rd_req && opt_reg.security)
        |-> prog_rd_refused && !prog_rd_valid && prog_rd_data == 16'h0000)
        else $error("protected read not refused");
    a_sec_readback: assert property ($past(clk_en)
        && $past(run && prog_rd_req && !opt_reg.security)
        |-> prog_rd_valid && prog_rd_data == $past(prog_rd_data_in))
        else $error("unprotected read not returned");
    a_lvr_map: assert property (run && $past(run) && $past(clk_en)
        |-> lvr_threshold_mv == cod_lvr_mv(opt_reg.low_voltage_reset) && lvr_sel == opt_reg.low_voltage_reset)
        else $error("threshold decode wrong");
    a_pwm_source: assert property ($past(clk_en) && $past(run) |->
        pwm_src_oscillator == $past(pwm_ctrl_bit0)
        && pwm_src_doubled == ($past(pwm_ctrl_bit0) & {3{opt_reg.pwm_fast}}))
        else $error("pwm clock source wrong");
    // Reset edge cleared the output, so the first edge after release is not judged
    a_cmp_gate: assert property ($past(clk_en) && $past(rst_n) |->
        pwm_out == ($past(opt_reg.gate)
        ? ($past(pwm_raw) & {3{$past(comparator_out)}}) : $past(pwm_raw)))
        else $error("pwm gating wrong");
    a_cmp_edge: assert property ($past(clk_en) && $past(run) |->
        comparator_irq_event
        == cod_edge_hit(opt_reg.edge_sel, $past(cmp_q_reg), $past(comparator_out)))
        else $error("comparator edge event wrong");
    a_src0_pick: assert property ($past(clk_en) && $past(rst_n) |->
        int_src0 == ($past(opt_reg.src0_alt) ? $past(port_b_bit5) : $past(port_a_bit0)))
        else $error("interrupt source 0 wrong");
    a_src1_pick: assert property ($past(clk_en) && $past(rst_n) |->
        int_src1 == ($past(opt_reg.src1_alt) ? $past(port_a_bit4) : $past(port_b_bit0)))
        else $error("interrupt source 1 wrong");
    a_opt_frozen: assert property (run ##1 1'b1 |-> $stable(opt_reg) && run)
        else $error("options changed after load");
    a_sticky_set: assert property ($past(clk_en) && $past(evt[`COD_EVT_CMP])
        |-> status_reg[`COD_EVT_CMP])
        else $error("event lost on clear");

    c_refused: cover property (prog_rd_req && run && opt_reg.security ##1 prog_rd_refused);
    c_cmp_irq: cover property (comparator_irq_event ##1 irq);
    c_gated: cover property (run && opt_reg.gate && pwm_raw != 3'h0 && !comparator_out);
endmodule
`default_nettype wire

// ### verif/code_option_decode_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "cod_defs.svh"
module code_option_decode_tb;
    logic mclk, rst_n, clk_en, prog_rd_req, comparator_out;
    logic port_a_bit0, port_b_bit5, port_b_bit0, port_a_bit4, reg_we, reg_re;
    logic [15:0] option_word, prog_rd_data_in, reg_wdata, prog_rd_data, reg_rdata, rd;
    logic [3:0] reg_addr, lvr_sel;
    logic [12:0] lvr_threshold_mv;
    logic [2:0] pwm_ctrl_bit0, pwm_raw, pwm_src_oscillator, pwm_src_doubled, pwm_out;
    logic [1:0] sysclk_dither;
    logic options_valid, prog_rd_valid, prog_rd_refused, comparator_irq_event;
    logic int_src0, int_src1, irq;
    int error_cnt = 0;
    int samples_checked = 0;
    // Threshold table in millivolts, index 0 is the highest level
    logic [15:0] lvr_mv [16] = '{16'h1194, 16'h0FA0, 16'h0EA6, 16'h0DAC, 16'h0CE4, 16'h0C4E,
        16'h0BB8, 16'h0A8C, 16'h09C4, 16'h0960, 16'h08FC, 16'h0898, 16'h0834, 16'h07D0,
        16'h076C, 16'h0708};

    // Short dither period keeps the triangle visible in a few cycles
    cod_top #(.DITHER_PERIOD(4)) uut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .option_word(option_word), .options_valid(options_valid), .prog_rd_req(prog_rd_req),
        .prog_rd_data_in(prog_rd_data_in), .prog_rd_data(prog_rd_data),
        .prog_rd_valid(prog_rd_valid), .prog_rd_refused(prog_rd_refused),
        .sysclk_dither(sysclk_dither), .lvr_sel(lvr_sel), .lvr_threshold_mv(lvr_threshold_mv),
        .pwm_ctrl_bit0(pwm_ctrl_bit0), .pwm_src_oscillator(pwm_src_oscillator),
        .pwm_src_doubled(pwm_src_doubled), .pwm_raw(pwm_raw), .comparator_out(comparator_out),
        .pwm_out(pwm_out), .comparator_irq_event(comparator_irq_event),
        .port_a_bit0(port_a_bit0), .port_b_bit5(port_b_bit5), .port_b_bit0(port_b_bit0),
        .port_a_bit4(port_a_bit4), .int_src0(int_src0), .int_src1(int_src1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .irq(irq));

    always #10 mclk = ~mclk;

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_we <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Options are caught only once, so every scenario starts from a fresh reset
    task automatic do_reset(input logic [15:0] opt);
        int n;
        @(posedge mclk);
        rst_n <= 1'b0;
        option_word <= opt;
        comparator_out <= 1'b0;
        {port_a_bit0, port_b_bit5, port_b_bit0, port_a_bit4} <= 4'h0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        n = 0;
        while (options_valid !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 20) begin
            error_cnt++;
            $display("wrong value at %0t: options never valid", $time);
            end_sim;
        end
        repeat (2) @(posedge mclk);
    endtask

    task automatic t_security;
        for (int s = 0; s < 2; s++) begin
            do_reset({15'h0000, 1'(s)});
            @(posedge mclk);
            prog_rd_req <= 1'b1;
            prog_rd_data_in <= 16'hA5C3;
            @(posedge mclk);
            prog_rd_data_in <= 16'h3C5A;
            #1;
            chk_bit(prog_rd_valid, s == 0);
            chk_bit(prog_rd_refused, s == 1);
            chk_word(prog_rd_data, (s == 1) ? 16'h0000 : 16'hA5C3);
            @(posedge mclk);
            prog_rd_req <= 1'b0;
            #1;
            chk_bit(prog_rd_valid, s == 0);
            chk_word(prog_rd_data, (s == 1) ? 16'h0000 : 16'h3C5A);
            @(posedge mclk);
            #1;
            chk_bit(prog_rd_valid | prog_rd_refused, 1'b0);
        end
    endtask

    // 24 cycles hold three whole up/down periods whatever the phase
    task automatic t_dither;
        int up, dn;
        for (int e = 0; e < 2; e++) begin
            do_reset({14'h0000, 1'(e), 1'b0});
            repeat (4) @(posedge mclk);
            up = 0;
            dn = 0;
            repeat (24) begin
                @(posedge mclk);
                #1;
                up += (sysclk_dither === 2'h1);
                dn += (sysclk_dither === 2'h3);
            end
            chk_word(16'(up), (e == 1) ? 16'h000C : 16'h0000);
            chk_word(16'(dn), (e == 1) ? 16'h000C : 16'h0000);
        end
    endtask

    task automatic t_lvr;
        for (int i = 0; i < 16; i++) begin
            do_reset({10'h000, 4'(i), 2'h0});
            #1;
            chk_word(16'(lvr_sel), 16'(i));
            chk_word(16'(lvr_threshold_mv), lvr_mv[i]);
        end
    endtask

    task automatic t_pwm;
        for (int f = 0; f < 2; f++) begin
            do_reset((f == 1) ? 16'h00C0 : 16'h0000);
            pwm_ctrl_bit0 <= 3'h6;
            pwm_raw <= 3'h7;
            repeat (2) @(posedge mclk);
            #1;
            chk_word(16'(pwm_src_oscillator), 16'h0006);
            chk_word(16'(pwm_src_doubled), (f == 1) ? 16'h0006 : 16'h0000);
            chk_word(16'(pwm_out), (f == 1) ? 16'h0000 : 16'h0007);
            @(posedge mclk);
            comparator_out <= 1'b1;
            pwm_ctrl_bit0 <= 3'h1;
            repeat (2) @(posedge mclk);
            #1;
            chk_word(16'(pwm_out), 16'h0007);
            chk_word(16'(pwm_src_doubled), (f == 1) ? 16'h0001 : 16'h0000);
        end
    endtask

    // Every edge mode, then the sticky status, mask and clear on the result
    task automatic t_edge;
        int cnt;
        for (int e = 0; e < 4; e++) begin
            do_reset({6'h00, 2'(e), 8'h00});
            cnt = 0;
            for (int ph = 0; ph < 2; ph++) begin
                @(posedge mclk);
                comparator_out <= (ph == 0);
                repeat (4) begin
                    @(posedge mclk);
                    #1;
                    cnt += (comparator_irq_event === 1'b1);
                end
            end
            chk_word(16'(cnt), (e == 1 || e == 2) ? 16'h0001 : 16'h0002);
            reg_rd(`COD_REG_STATUS, rd);
            chk_word(rd, 16'h0001);
            chk_bit(irq, 1'b0);
            reg_wr(`COD_REG_MASK, 16'h0001);
            #1;
            chk_bit(irq, 1'b1);
            reg_wr(`COD_REG_STATUS, 16'h0001);
            #1;
            chk_bit(irq, 1'b0);
        end
    endtask

    task automatic t_src;
        for (int a = 0; a < 2; a++) begin
            do_reset((a == 1) ? 16'h0C00 : 16'h0000);
            {port_a_bit0, port_b_bit5, port_b_bit0, port_a_bit4} <= 4'h9;
            repeat (2) @(posedge mclk);
            #1;
            chk_bit(int_src0, a == 0);
            chk_bit(int_src1, a == 1);
            @(posedge mclk);
            {port_a_bit0, port_b_bit5, port_b_bit0, port_a_bit4} <= 4'h6;
            repeat (2) @(posedge mclk);
            #1;
            chk_bit(int_src0, a == 1);
            chk_bit(int_src1, a == 0);
            reg_rd(`COD_REG_STATUS, rd);
            chk_word(rd, 16'h0006);
        end
    endtask

    // Software and a moving option word must leave the latched choice alone
    task automatic t_frozen;
        do_reset(16'h0A5C);
        reg_rd(`COD_REG_STATUS, rd);
        chk_word(rd, 16'h0000);
        reg_rd(`COD_REG_MASK, rd);
        chk_word(rd, 16'h0000);
        @(posedge mclk);
        option_word <= 16'h0000;
        reg_wr(`COD_REG_OPTION, 16'h0000);
        reg_wr(4'hF, 16'hFFFF);
        reg_wr(`COD_REG_MASK, 16'h0007);
        reg_rd(`COD_REG_OPTION, rd);
        chk_word(rd, 16'h0A5C);
        chk_word(16'(lvr_sel), 16'h0007);
        reg_rd(4'hF, rd);
        chk_word(rd, 16'h0000);
        reg_rd(`COD_REG_MASK, rd);
        chk_word(rd, 16'h0007);
        // Clock enable low must freeze the selected source, then let it move
        @(posedge mclk);
        clk_en <= 1'b0;
        port_a_bit4 <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk_bit(int_src1, 1'b0);
        @(posedge mclk);
        clk_en <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk_bit(int_src1, 1'b1);
        chk_bit(irq, 1'b1);
    endtask

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        option_word = 16'h0000;
        prog_rd_req = 1'b0;
        prog_rd_data_in = 16'h0000;
        pwm_ctrl_bit0 = 3'h0;
        pwm_raw = 3'h0;
        comparator_out = 1'b0;
        {port_a_bit0, port_b_bit5, port_b_bit0, port_a_bit4} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_we = 1'b0;
        reg_re = 1'b0;
        t_security;
        t_dither;
        t_lvr;
        t_pwm;
        t_edge;
        t_src;
        t_frozen;
        end_sim;
    end

    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim;
    end
endmodule
`default_nettype wire
